// >>> rtl/wdc_pkg.sv
/*
  Constants, register map and carrier types of the watchdog control block.
  Assumes a single 100 MHz clock and an 8-bit register port.
*/
package wdc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and timebase.
  localparam int unsigned CLK_FREQ_HZ       = 100_000_000;
  localparam int unsigned TB_FREQ_HZ        = 32_768;
  localparam int unsigned TB_DIV_CYCLES     = CLK_FREQ_HZ / TB_FREQ_HZ;
  localparam int unsigned TB_DIV_W          = 12;
  localparam int unsigned TIMEOUT_BASE_TICKS = 512;
  localparam int unsigned TIMEOUT_CNT_W     = 17;
  localparam int unsigned TIMEOUT0_US       = 15_600;

  ////////////////////////////////////////////////////////////////////////////////
  // Register offsets.
  localparam logic [7:0] ADDR_CONTROL   = 8'h00;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h01;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h02;
  localparam logic [7:0] ADDR_IRQ_CLR   = 8'h03;

  // Field positions of the control register.
  localparam int unsigned POS_PRESCALE  = 4;
  localparam int unsigned POS_INT_SEL   = 3;
  localparam int unsigned POS_FLAG      = 2;
  localparam int unsigned POS_RUN       = 1;
  localparam int unsigned POS_UNLOCK    = 0;

  // Prescale codes.
  localparam logic [3:0] PRE_IMMEDIATE  = 4'h8;

  // Interrupt status bits.
  localparam int unsigned IRQ_W         = 2;
  localparam int unsigned IRQ_TIMEOUT   = 0;
  localparam int unsigned IRQ_REFUSED   = 1;

  // Values after reset.
  localparam logic [3:0] RST_PRESCALE   = 4'h0;
  localparam logic [1:0] RST_IRQ_EN     = 2'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef enum logic [1:0] {
    WDC_LOCKED   = 2'b00,
    WDC_SET_PEND = 2'b01,
    WDC_ARMED    = 2'b10
  } wdc_unlock_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wdc_bus_req_type;

  typedef struct packed {
    logic [3:0] prescale;
    logic       int_sel;
    logic       flag;
    logic       run;
    logic       unlock;
  } wdc_ctrl_type;

endpackage

// >>> rtl/wdc_timeout_counter.sv
/*
  Timebase divider and timeout counter of the watchdog.
  Assumes the clear and run inputs come from logic on the same clock.
*/
`timescale 1ns/1ps
module wdc_timeout_counter #(
  parameter int unsigned DIV_CYCLES = wdc_pkg::TB_DIV_CYCLES
) (
  input  wire logic       ref_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       run_in,
  input  wire logic       clear_in,
  input  wire logic [3:0] prescale_in,
  output logic            expired_out
);

  logic [wdc_pkg::TB_DIV_W-1:0]      div_r;
  logic [wdc_pkg::TIMEOUT_CNT_W-1:0] cnt_r;
  logic                              tick;
  logic [wdc_pkg::TIMEOUT_CNT_W-1:0] limit;
  logic                              valid_pre;

  ////////////////////////////////////////////////////////////////////////////////
  // The period is two to the prescale times the base tick count.
  assign tick      = run_in && (div_r == wdc_pkg::TB_DIV_W'(DIV_CYCLES - 1));
  assign limit     = (wdc_pkg::TIMEOUT_CNT_W'(wdc_pkg::TIMEOUT_BASE_TICKS) << prescale_in[2:0])
                     - wdc_pkg::TIMEOUT_CNT_W'(1); // RL1
  assign valid_pre = (prescale_in < wdc_pkg::PRE_IMMEDIATE); // RL2
  assign expired_out = tick && valid_pre && (cnt_r == limit); // RL1

  // The divider restarts with the count so that a restart gives a full period.
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in || clear_in || !run_in || tick)
    begin
      div_r <= '0;
    end
    else
    begin
      div_r <= div_r + wdc_pkg::TB_DIV_W'(1);
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in || clear_in || expired_out) // RL6
    begin
      cnt_r <= '0;
    end
    else if (tick && valid_pre)
    begin
      cnt_r <= cnt_r + wdc_pkg::TIMEOUT_CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  AST_CLEAR_RESTARTS: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RL6
    clear_in |=> (cnt_r == '0) && (div_r == '0))
    else $error("Counter not restarted by clear.");

  AST_RESERVED_SILENT: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RL2
    (prescale_in > wdc_pkg::PRE_IMMEDIATE) |-> !expired_out)
    else $error("Reserved prescale produced a timeout.");

endmodule

// >>> rtl/wdc_watchdog_ctrl.sv
/*
  Watchdog control register, unlock sequence, timeout response and interrupt status.
  Assumes the core pulses instr_done_in at the end of every instruction and that
  a register write belonging to an instruction comes no later than its pulse.
*/
// Overview of operation
// RL1: Timeout is two to the prescale times 512 timebase ticks, 15.6 ms at zero.
// RL2: Prescale 1000 resets at once; higher codes are reserved and never time out.
// RL3: Unrestarted timeout gives a reset or an interrupt, chosen by bit 3.
// RL4: The timeout interrupt is high priority and ignores the global interrupt enable.
// RL5: Bit 2 sets on each timeout, clears by writing zero or hardware reset.
// RL6: Writing one to bit 1 enables the watchdog and restarts its counters.
// RL7: Bit 1 clears on write zero, reset response, hardware reset, supply monitor.
// RL8: A control write is taken only in the instruction right after setting bit 0.
// RL9: Software disables global interrupts before starting the unlock sequence.
// RL10: The unlock bit drops after one write or any other intervening instruction.
`timescale 1ns/1ps
module wdc_watchdog_ctrl #(
  parameter int unsigned DIV_CYCLES = wdc_pkg::TB_DIV_CYCLES
) (
  input  wire logic                    ref_clk_in,
  input  wire logic                    sys_rst_in,
  input  wire wdc_pkg::wdc_bus_req_type bus_req_in,
  output logic [7:0]                   bus_rdata_out,
  input  wire logic                    instr_done_in,
  input  wire logic                    supply_monitor_irq_in,
  input  wire logic                    global_interrupt_enable_in,
  output logic                         watchdog_reset_out,
  output logic                         timeout_irq_out,
  output logic                         irq_out
);

  wdc_pkg::wdc_unlock_type     unlock_r;
  wdc_pkg::wdc_unlock_type     unlock_nxt;
  logic [3:0]                  prescale_r;
  logic                        int_sel_r;
  logic                        flag_r;
  logic                        run_r;
  logic                        restart_r;
  logic                        reset_r;
  logic [wdc_pkg::IRQ_W-1:0]   irq_stat_r;
  logic [wdc_pkg::IRQ_W-1:0]   irq_en_r;
  logic [7:0]                  rdata_r;
  logic                        ctrl_wr;
  logic                        accept_wr;
  logic                        refused_wr;
  logic                        unlock_wr;
  logic                        clr_wr;
  logic                        en_wr;
  logic                        expired;
  logic                        immediate;
  logic                        timeout_evt;
  logic                        reset_evt;
  logic                        irq_evt;
  logic [wdc_pkg::IRQ_W-1:0]   irq_set;
  wdc_pkg::wdc_ctrl_type       ctrl_view;
  logic [7:0]                  rdata_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode and unlock gating.
  assign ctrl_wr    = bus_req_in.wr && (bus_req_in.addr == wdc_pkg::ADDR_CONTROL);
  assign accept_wr  = ctrl_wr && (unlock_r == wdc_pkg::WDC_ARMED); // RL8
  assign unlock_wr  = ctrl_wr && !accept_wr && bus_req_in.wdata[wdc_pkg::POS_UNLOCK];
  assign refused_wr = ctrl_wr && !accept_wr && !bus_req_in.wdata[wdc_pkg::POS_UNLOCK];
  assign clr_wr     = bus_req_in.wr && (bus_req_in.addr == wdc_pkg::ADDR_IRQ_CLR);
  assign en_wr      = bus_req_in.wr && (bus_req_in.addr == wdc_pkg::ADDR_IRQ_EN);

  // The unlocking instruction may end in the cycle of its own write, so arm at once then.
  always_comb
  begin
    unlock_nxt = unlock_r;
    case (unlock_r)
      wdc_pkg::WDC_LOCKED:
      begin
        if (unlock_wr)
        begin
          unlock_nxt = instr_done_in ? wdc_pkg::WDC_ARMED : wdc_pkg::WDC_SET_PEND;
        end
      end
      wdc_pkg::WDC_SET_PEND:
      begin
        if (instr_done_in)
        begin
          unlock_nxt = wdc_pkg::WDC_ARMED;
        end
      end
      wdc_pkg::WDC_ARMED:
      begin
        if (accept_wr || instr_done_in) // RL10
        begin
          unlock_nxt = wdc_pkg::WDC_LOCKED;
        end
      end
      default:
      begin
        unlock_nxt = wdc_pkg::WDC_LOCKED;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      unlock_r <= wdc_pkg::WDC_LOCKED;
    end
    else
    begin
      unlock_r <= unlock_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Timeout detection and response.
  wdc_timeout_counter #(
    .DIV_CYCLES (DIV_CYCLES)
  ) u_counter (
    .ref_clk_in  (ref_clk_in),
    .sys_rst_in  (sys_rst_in),
    .run_in      (run_r),
    .clear_in    (restart_r),
    .prescale_in (prescale_r),
    .expired_out (expired)
  );

  assign immediate   = run_r && (prescale_r == wdc_pkg::PRE_IMMEDIATE); // RL2
  assign timeout_evt = expired || immediate;
  assign reset_evt   = immediate || (expired && !int_sel_r); // RL3
  assign irq_evt     = expired && int_sel_r; // RL3

  // Only a hardware reset clears the prescale and interrupt select fields; a watchdog reset leaves the flag.
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      prescale_r <= wdc_pkg::RST_PRESCALE;
      int_sel_r  <= 1'b0;
    end
    else if (accept_wr)
    begin
      prescale_r <= bus_req_in.wdata[wdc_pkg::POS_PRESCALE +: 4];
      int_sel_r  <= bus_req_in.wdata[wdc_pkg::POS_INT_SEL];
    end
  end

  // A timeout in the cycle of a clearing write still sets the flag.
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      flag_r <= 1'b0;
    end
    else if (timeout_evt) // RL5
    begin
      flag_r <= 1'b1;
    end
    else if (accept_wr && !bus_req_in.wdata[wdc_pkg::POS_FLAG]) // RL5
    begin
      flag_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in || supply_monitor_irq_in || reset_evt) // RL7
    begin
      run_r <= 1'b0;
    end
    else if (accept_wr)
    begin
      run_r <= bus_req_in.wdata[wdc_pkg::POS_RUN]; // RL6
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      restart_r <= 1'b0;
      reset_r   <= 1'b0;
    end
    else
    begin
      restart_r <= accept_wr && bus_req_in.wdata[wdc_pkg::POS_RUN]; // RL6
      reset_r   <= reset_evt; // RL3
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status, enable and clear.
  assign irq_set = {refused_wr, irq_evt};

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      irq_stat_r <= '0;
      irq_en_r   <= wdc_pkg::RST_IRQ_EN;
    end
    else
    begin
      irq_stat_r <= irq_set | (irq_stat_r & ~(clr_wr ? bus_req_in.wdata[wdc_pkg::IRQ_W-1:0]
                                                    : {wdc_pkg::IRQ_W{1'b0}}));
      if (en_wr)
      begin
        irq_en_r <= bus_req_in.wdata[wdc_pkg::IRQ_W-1:0];
      end
    end
  end

  // The global interrupt enable is deliberately not looked at here.
  assign irq_out            = |(irq_stat_r & irq_en_r); // RL4
  assign timeout_irq_out    = irq_stat_r[wdc_pkg::IRQ_TIMEOUT]
                              && irq_en_r[wdc_pkg::IRQ_TIMEOUT]; // RL4
  assign watchdog_reset_out = reset_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Read port.
  assign ctrl_view = '{prescale: prescale_r, int_sel: int_sel_r, flag: flag_r, run: run_r,
                       unlock: (unlock_r != wdc_pkg::WDC_LOCKED)};

  assign rdata_nxt = !bus_req_in.rd ? 8'h00 :
                     (bus_req_in.addr == wdc_pkg::ADDR_CONTROL)  ? ctrl_view :
                     (bus_req_in.addr == wdc_pkg::ADDR_IRQ_STAT) ? {6'h00, irq_stat_r} :
                     (bus_req_in.addr == wdc_pkg::ADDR_IRQ_EN)   ? {6'h00, irq_en_r} :
                     8'h00;

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      rdata_r <= 8'h00;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  assign bus_rdata_out = rdata_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence unlock_seq;
    (unlock_r == wdc_pkg::WDC_ARMED) && ctrl_wr;
  endsequence

  sequence unlock_done_seq;
    unlock_r == wdc_pkg::WDC_LOCKED;
  endsequence

  sequence arm_seq;
    (unlock_r == wdc_pkg::WDC_SET_PEND) && instr_done_in;
  endsequence

  AST_IMMEDIATE_RESET: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RL2
    immediate |=> watchdog_reset_out && !run_r)
    else $error("Prescale code eight did not reset at once.");

  AST_RESET_RESPONSE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RL3
    (expired && !int_sel_r) |=> watchdog_reset_out && !run_r)
    else $error("Timeout with reset response gave no reset.");

  // A supply monitor event or a stopping write in the expiry cycle may clear the run bit.
  AST_IRQ_RESPONSE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RL3
    (expired && int_sel_r && !immediate && !supply_monitor_irq_in
      && !(accept_wr && !bus_req_in.wdata[wdc_pkg::POS_RUN]))
      |=> !watchdog_reset_out && irq_stat_r[wdc_pkg::IRQ_TIMEOUT] && run_r)
    else $error("Timeout with interrupt response misbehaved.");

  AST_IRQ_UNGATED: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RL4
    (!global_interrupt_enable_in && irq_stat_r[wdc_pkg::IRQ_TIMEOUT]
      && irq_en_r[wdc_pkg::IRQ_TIMEOUT]) |-> timeout_irq_out && irq_out)
    else $error("Timeout interrupt masked by global enable.");

  AST_FLAG_SET: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RL5
    timeout_evt |=> flag_r ##1 (flag_r || $past(accept_wr)))
    else $error("Timeout flag not set.");

  AST_FLAG_STICKY: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RL5
    (flag_r && !(accept_wr && !bus_req_in.wdata[wdc_pkg::POS_FLAG])) |=> flag_r)
    else $error("Timeout flag dropped without a clearing write.");

  AST_RUN_WRITE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RL6
    (accept_wr && bus_req_in.wdata[wdc_pkg::POS_RUN] && !supply_monitor_irq_in && !reset_evt)
      |=> run_r && restart_r)
    else $error("Enable write did not start and restart the watchdog.");

  AST_RUN_CLEAR: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RL7
    (supply_monitor_irq_in || reset_evt) |=> !run_r)
    else $error("Enable bit survived a clearing event.");

  AST_LOCKED_WRITE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RL8
    (ctrl_wr && (unlock_r != wdc_pkg::WDC_ARMED)) |=> $stable(prescale_r) && $stable(int_sel_r))
    else $error("Control register changed without the unlock sequence.");

  AST_ARM_AFTER_SET: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RL8
    arm_seq |=> unlock_r == wdc_pkg::WDC_ARMED)
    else $error("Unlock not armed at the end of the unlocking instruction.");

  AST_REFUSED_STATUS: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RL8
    refused_wr |=> irq_stat_r[wdc_pkg::IRQ_REFUSED])
    else $error("Refused control write not reported.");

  AST_ONE_SHOT_UNLOCK: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RL10
    unlock_seq |=> unlock_done_seq)
    else $error("Unlock stayed open after a write.");

  AST_UNLOCK_LAPSE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RL10
    ((unlock_r == wdc_pkg::WDC_ARMED) && instr_done_in) |=> unlock_done_seq)
    else $error("Unlock survived an intervening instruction.");

endmodule

// >>> tb/testbench.sv
/*
  Self-checking bench of the watchdog control block: register port, unlock, timeouts, interrupts.
  Assumes the design package is compiled first and the design holds its own assertions.
*/
`timescale 1ns/1ps
module testbench;
  ////////////////////////////////////////////////////////////////////////////////
  // The divider is shortened so a whole timeout fits into a short run.
  localparam int DIV   = 4;
  localparam int T0    = 512 * DIV;
  localparam int LIMIT = 60000;

  logic                     ref_clk_in;
  logic                     sys_rst_in;
  logic                     instr_done_in;
  logic                     supply_monitor_irq_in;
  logic                     global_interrupt_enable_in;
  wdc_pkg::wdc_bus_req_type bus_req;
  logic [7:0]               bus_rdata_out;
  logic                     watchdog_reset_out;
  logic                     timeout_irq_out;
  logic                     irq_out;
  logic [7:0]               exp_q[$];
  logic                     rd_q;
  logic [31:0]              seed;
  int                       num_errors;
  int                       n_tests;
  int                       n_rst;
  int                       cyc;
  int                       k;

  wdc_watchdog_ctrl #(
    .DIV_CYCLES (DIV)
  ) dut (
    .ref_clk_in                 (ref_clk_in),
    .sys_rst_in                 (sys_rst_in),
    .bus_req_in                 (bus_req),
    .bus_rdata_out              (bus_rdata_out),
    .instr_done_in              (instr_done_in),
    .supply_monitor_irq_in      (supply_monitor_irq_in),
    .global_interrupt_enable_in (global_interrupt_enable_in),
    .watchdog_reset_out         (watchdog_reset_out),
    .timeout_irq_out            (timeout_irq_out),
    .irq_out                    (irq_out)
  );

  initial ref_clk_in = 1'b0;
  always #5 ref_clk_in = ~ref_clk_in;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s;
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic done);
    @(posedge ref_clk_in);
    bus_req       <= {1'b1, 1'b0, a, d};
    instr_done_in <= done;
    @(posedge ref_clk_in);
    bus_req       <= '0;
    instr_done_in <= 1'b0;
  endtask

  // The expected byte is queued here; the watcher pairs it with the data cycle.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    @(posedge ref_clk_in);
    bus_req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk_in);
    bus_req <= '0;
  endtask

  task automatic instr();
    @(posedge ref_clk_in);
    instr_done_in <= 1'b1;
    @(posedge ref_clk_in);
    instr_done_in <= 1'b0;
  endtask

  // Interrupts are held off across the two-step unlock, as software must do.
  task automatic ctl(input logic [7:0] d);
    global_interrupt_enable_in <= 1'b0;
    wr(wdc_pkg::ADDR_CONTROL, 8'h01, 1'b1);
    wr(wdc_pkg::ADDR_CONTROL, d, 1'b1);
    global_interrupt_enable_in <= 1'b1;
  endtask

  // Samples on the falling edge so a one-cycle pulse is never missed or raced.
  task automatic wait_evt(input int t, input bit irq);
    int n;
    n = 0;
    while (((irq ? timeout_irq_out : watchdog_reset_out) !== 1'b1) && n < t + 50)
    begin
      @(negedge ref_clk_in);
      n++;
    end
    check({7'h00, (n >= t - 8 && n <= t + 8)}, 8'h01);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk_in)
  begin
    if (watchdog_reset_out === 1'b1)
      n_rst++;
    if (rd_q === 1'b1)
      check(bus_rdata_out, exp_q.pop_front());
    rd_q <= bus_req.rd;
  end

  always @(posedge ref_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      num_errors++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    num_errors = 0;
    n_tests = 0;
    n_rst = 0;
    cyc = 0;
    rd_q = 1'b0;
    seed = 32'h2A8E;
    bus_req = '0;
    instr_done_in = 1'b0;
    supply_monitor_irq_in = 1'b0;
    global_interrupt_enable_in = 1'b1;
    sys_rst_in = 1'b1;
    repeat (5) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h00);
    rd(8'h07, 8'h00);
    repeat (4)
    begin
      seed = xs(seed);
      wr(8'h02, {6'h00, seed[1:0]}, 1'b0);
      wr(8'h01, seed[15:8], 1'b0);
      rd(8'h02, {6'h00, seed[1:0]});
      rd(8'h01, 8'h00);
    end
    wr(8'h02, 8'h02, 1'b0);
    wr(8'h00, 8'h72, 1'b1);
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h02);
    @(negedge ref_clk_in);
    check({7'h00, irq_out}, 8'h01);
    wr(8'h03, 8'h02, 1'b0);
    rd(8'h01, 8'h00);
    @(negedge ref_clk_in);
    check({7'h00, irq_out}, 8'h00);
    wr(8'h00, 8'h01, 1'b0);
    rd(8'h00, 8'h01);
    instr();
    instr();
    rd(8'h00, 8'h00);
    wr(8'h00, 8'h72, 1'b1);
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h02);
    wr(8'h03, 8'h03, 1'b0);
    ctl(8'h02);
    wait_evt(T0, 1'b0);
    rd(8'h00, 8'h04);
    ctl(8'h12);
    wait_evt(2 * T0, 1'b0);
    rd(8'h00, 8'h14);
    ctl(8'h02);
    seed = xs(seed);
    repeat (1200 + int'(seed[7:0])) @(posedge ref_clk_in);
    ctl(8'h02);
    wait_evt(T0, 1'b0);
    ctl(8'h00);
    rd(8'h00, 8'h00);
    wr(8'h03, 8'h03, 1'b0);
    wr(8'h02, 8'h01, 1'b0);
    k = n_rst;
    ctl(8'h0A);
    @(posedge ref_clk_in);
    global_interrupt_enable_in <= 1'b0;
    wait_evt(T0, 1'b1);
    check({7'h00, irq_out}, 8'h01);
    check(n_rst[7:0], k[7:0]);
    rd(8'h00, 8'h0E);
    rd(8'h01, 8'h01);
    wr(8'h03, 8'h01, 1'b0);
    @(negedge ref_clk_in);
    check({7'h00, timeout_irq_out}, 8'h00);
    @(posedge ref_clk_in);
    supply_monitor_irq_in <= 1'b1;
    @(posedge ref_clk_in);
    supply_monitor_irq_in <= 1'b0;
    rd(8'h00, 8'h0C);
    ctl(8'h82);
    wait_evt(1, 1'b0);
    rd(8'h00, 8'h84);
    k = n_rst;
    ctl(8'h92);
    repeat (3 * T0) @(posedge ref_clk_in);
    check(n_rst[7:0], k[7:0]);
    rd(8'h00, 8'h92);
    ctl(8'h82);
    rd(8'h00, 8'h84);
    wr(8'h00, 8'h00, 1'b0);
    rd(8'h01, 8'h02);
    @(posedge ref_clk_in);
    sys_rst_in <= 1'b1;
    @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h00);
    repeat (3) @(posedge ref_clk_in);
    check(8'(exp_q.size()), 8'h00);
    complete_run();
  end
endmodule
